// [core/sssq_pkg.sv]
// Constants, modes and states of the standby/sleep sequencer.
// Assumes a single 20 MHz clock; all users write sssq_pkg::name.
package sssq_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int STANDBY_MS = 250;
  // Whole cycles in the standby timeout
  localparam int STANDBY_CYC = CLK_HZ / 1000 * STANDBY_MS;
  localparam logic [22:0] TIMER_ZERO = 23'h000000;
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [2:0] SYNC_RST = 3'h0;

  typedef enum logic [3:0] {
    ST_SLEEP = 4'h1,
    ST_STANDBY = 4'h2,
    ST_ACTIVE = 4'h4,
    ST_GOSLEEP = 4'h8
  } sssq_state_t;
endpackage

// [core/sssq_top.sv]
// Standby/sleep sequencer with regulator inhibit control and pin conditioning.
// Assumes mode, wake-up and supply/ground monitors arrive asynchronously.
`timescale 1ns/1ns
module sssq_top #(
  parameter int TIMEOUT_CYC = sssq_pkg::STANDBY_CYC
) (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // Host pins
  input wire logic MODE_SELECT_0,
  input wire logic MODE_SELECT_1,
  input wire logic TXD,
  output logic RXD_O,
  output logic RXD_OE_N,
  // Analog front-end status
  input wire logic HIGH_VOLTAGE_WAKEUP,
  input wire logic BUS_DOMINANT_SENSE,
  input wire logic UNDERVOLTAGE,
  input wire logic LOSS_OF_GROUND,
  // Actuators and sleep status
  output logic REGULATOR_INHIBIT_OUT,
  output logic BUS_LINE_DRIVE,
  output logic LOAD_GND_EN,
  output logic SLEEP_STATUS
);
  typedef struct packed {
    logic [2:0] s_m0;
    logic [2:0] s_m1;
    logic [2:0] s_wu;
    logic [2:0] s_uv;
    logic [2:0] s_lg;
    logic [2:0] s_bus;
    logic [2:0] s_tx;
    logic m0, m1, wu, uv, lg, bus;
    logic tx;
    logic started;
    sssq_pkg::sssq_state_t state;
    logic [22:0] timer;
    logic wake_irq;
    logic regulator_inhibit_out, drive, load_en, rxd_lo;
  } sssq_reg_t;

  sssq_reg_t r;
  sssq_reg_t next_r;
  logic [1:0] mode;
  logic active_sel;

  // Three-stage sync; a change counts once stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  assign mode = {r.m1, r.m0};
  // Undriven pins read 0,0 which is sleep
  assign active_sel = (mode != sssq_pkg::MODE_SLEEP);

  // Next-state logic
  always_comb begin
    next_r = r;
    next_r.s_m0 = {r.s_m0[1:0], MODE_SELECT_0};
    next_r.s_m1 = {r.s_m1[1:0], MODE_SELECT_1};
    next_r.s_wu = {r.s_wu[1:0], HIGH_VOLTAGE_WAKEUP};
    next_r.s_uv = {r.s_uv[1:0], UNDERVOLTAGE};
    next_r.s_lg = {r.s_lg[1:0], LOSS_OF_GROUND};
    next_r.s_bus = {r.s_bus[1:0], BUS_DOMINANT_SENSE};
    next_r.m0 = filt(r.s_m0, r.m0);
    next_r.m1 = filt(r.s_m1, r.m1);
    next_r.wu = filt(r.s_wu, r.wu);
    next_r.uv = filt(r.s_uv, r.uv);
    next_r.lg = filt(r.s_lg, r.lg);
    next_r.bus = filt(r.s_bus, r.bus);
    // Transmit pin is asynchronous too; filtered like the others
    next_r.s_tx = {r.s_tx[1:0], TXD};
    next_r.tx = filt(r.s_tx, r.tx);
    next_r.started = 1'b1;
    if (r.timer != sssq_pkg::TIMER_ZERO) begin
      next_r.timer = r.timer - 23'h000001; // Internal timebase
    end
    case (r.state)
      sssq_pkg::ST_SLEEP: begin
        if (!r.started) begin
          // Power-on: go to standby with full preset
          next_r.state = sssq_pkg::ST_STANDBY;
          next_r.timer = TIMEOUT_CYC[22:0];
        end else if (r.wu) begin
          next_r.state = sssq_pkg::ST_STANDBY;
          next_r.timer = TIMEOUT_CYC[22:0];
          next_r.wake_irq = 1'b1;
        end else if (active_sel) begin
          next_r.state = sssq_pkg::ST_ACTIVE;
        end
      end
      sssq_pkg::ST_STANDBY: begin
        if (active_sel) begin
          next_r.state = sssq_pkg::ST_ACTIVE; // Timer keeps counting down, unused
          next_r.wake_irq = 1'b0;
        end else if (r.wu) begin
          next_r.timer = TIMEOUT_CYC[22:0]; // Reload every cycle while wake-up is present
        end else if (r.timer == sssq_pkg::TIMER_ZERO) begin
          next_r.state = sssq_pkg::ST_SLEEP;
          next_r.wake_irq = 1'b0;
        end
      end
      sssq_pkg::ST_ACTIVE: begin
        if (!active_sel) begin
          next_r.state = sssq_pkg::ST_GOSLEEP; // Delayed release
          next_r.timer = TIMEOUT_CYC[22:0];
        end
      end
      sssq_pkg::ST_GOSLEEP: begin
        if (active_sel) begin
          next_r.state = sssq_pkg::ST_ACTIVE;
        end else if (r.wu) begin
          next_r.timer = TIMEOUT_CYC[22:0]; // Wake-up present holds inhibit
        end else if (r.timer == sssq_pkg::TIMER_ZERO) begin
          next_r.state = sssq_pkg::ST_SLEEP;
        end
      end
      default: begin
        next_r.state = sssq_pkg::ST_SLEEP;
      end
    endcase
    // Inhibit high in every state except sleep
    next_r.regulator_inhibit_out = (next_r.state != sssq_pkg::ST_SLEEP) || !next_r.started;
    // No dominant drive in sleep or undervoltage; ground loss alone keeps it
    next_r.drive = !r.tx && !r.uv && (r.state != sssq_pkg::ST_SLEEP);
    next_r.load_en = !r.lg;
    // Receive: bus data in active only, interrupt low after wake-up
    next_r.rxd_lo = !r.uv && ((r.state == sssq_pkg::ST_STANDBY && r.wake_irq)
                    || (r.state == sssq_pkg::ST_ACTIVE && r.bus));
  end

  // State register; clock enable freezes everything but reset
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      r <= '0;
      r.state <= sssq_pkg::ST_SLEEP;
      r.s_m0 <= sssq_pkg::SYNC_RST;
      r.load_en <= 1'b1;
      // Transmit sync starts recessive, so no dominant pulse follows reset
      r.s_tx <= 3'h7;
      r.tx <= 1'b1;
    end else if (CLK_EN) begin
      r <= next_r;
    end
  end

  // Open-drain receive: enable is low while driving low
  assign RXD_O = 1'b0;
  assign RXD_OE_N = !r.rxd_lo;
  assign REGULATOR_INHIBIT_OUT = r.regulator_inhibit_out;
  assign BUS_LINE_DRIVE = r.drive;
  assign LOAD_GND_EN = r.load_en;
  assign SLEEP_STATUS = (r.state == sssq_pkg::ST_SLEEP);
endmodule

// [sim/sssq_chk.sv]
// Port checker for the sequencer.
// Assumes CLK_EN held high; bound below.
`timescale 1ns/1ns
module sssq_chk #(parameter int TIMEOUT_CYC = 50) (
  // Watched ports
  input wire logic CLK, SYS_RST, MODE_SELECT_0, MODE_SELECT_1, TXD, HIGH_VOLTAGE_WAKEUP,
  input wire logic UNDERVOLTAGE, LOSS_OF_GROUND, REGULATOR_INHIBIT_OUT, BUS_LINE_DRIVE,
  input wire logic LOAD_GND_EN, RXD_OE_N, SLEEP_STATUS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  int idle;
  // Idle run length, so timeout bounds need no unrolling
  always_ff @(posedge CLK)
    idle <= (SYS_RST | MODE_SELECT_0 | MODE_SELECT_1 | HIGH_VOLTAGE_WAKEUP) ? 0 : idle + 1;
  sequence s_wake; $rose(HIGH_VOLTAGE_WAKEUP) ##1 HIGH_VOLTAGE_WAKEUP [*6]; endsequence
  property p_por; $fell(SYS_RST) |-> ##[0:2] REGULATOR_INHIBIT_OUT; endproperty
  property p_tmin; $fell(REGULATOR_INHIBIT_OUT) |-> idle >= TIMEOUT_CYC; endproperty
  property p_tmax; idle == TIMEOUT_CYC + 12 |-> !REGULATOR_INHIBIT_OUT; endproperty
  property p_wake; s_wake |-> REGULATOR_INHIBIT_OUT && !SLEEP_STATUS; endproperty
  property p_act; (MODE_SELECT_0 | MODE_SELECT_1) [*6] |-> REGULATOR_INHIBIT_OUT; endproperty
  property p_load; $stable(LOSS_OF_GROUND) [*6] |-> LOAD_GND_EN != LOSS_OF_GROUND; endproperty
  property p_uv; UNDERVOLTAGE [*6] |-> !BUS_LINE_DRIVE && RXD_OE_N; endproperty
  property p_tx; (!TXD && !UNDERVOLTAGE && !SLEEP_STATUS) [*6] |-> BUS_LINE_DRIVE; endproperty
  a_por: assert property (p_por) else $error("no inhibit at power-on");
  a_tmin: assert property (p_tmin) else $error("inhibit fell early");
  a_tmax: assert property (p_tmax) else $error("inhibit held late");
  a_wake: assert property (p_wake) else $error("wake ignored");
  a_act: assert property (p_act) else $error("inhibit low in active");
  a_load: assert property (p_load) else $error("load path wrong");
  a_uv: assert property (p_uv) else $error("bus not passive");
  a_tx: assert property (p_tx) else $error("drive stopped");
endmodule
bind sssq_top sssq_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (.*);

// [sim/sssq_host.sv]
// Host model on the mode pins.
// Assumes pulldown nets; a released pin reads low.
`timescale 1ns/1ns
module sssq_host (
  // Mode pins
  output wire logic ms0,
  output wire logic ms1
);
  logic [1:0] m = 2'h0;
  logic en = 1'b0;
  // Released pins float, pulldowns then select sleep
  assign ms0 = en ? m[0] : 1'bz;
  assign ms1 = en ? m[1] : 1'bz;
  // Drive a mode code or let go
  task automatic set(input logic on, input logic [1:0] v);
    en = on;
    m = v;
  endtask
endmodule

// [sim/sssq_tb.sv]
// Bench for the sequencer; integer timer model.
// Assumes a short timeout parameter.
`timescale 1ns/1ns
module sssq_tb;
  localparam int T = 50;
  logic clk = 1'b0, rst = 1'b1, txd = 1'b1, wk = 1'b0, uv = 1'b0, lg = 1'b0;
  tri0 ms0, ms1;
  wire regulator_inhibit_out, drv, lden, oen, slp, rxo;
  int errors = 0, comparisons = 0, left = T;
  sssq_host host (.ms0(ms0), .ms1(ms1));
  sssq_top #(.TIMEOUT_CYC(T)) dut (.CLK(clk), .SYS_RST(rst), .CLK_EN(1'b1),
    .MODE_SELECT_0(ms0), .MODE_SELECT_1(ms1), .TXD(txd), .RXD_O(rxo), .RXD_OE_N(oen),
    .HIGH_VOLTAGE_WAKEUP(wk), .BUS_DOMINANT_SENSE(!txd), .UNDERVOLTAGE(uv),
    .LOSS_OF_GROUND(lg), .REGULATOR_INHIBIT_OUT(regulator_inhibit_out), .BUS_LINE_DRIVE(drv),
    .LOAD_GND_EN(lden), .SLEEP_STATUS(slp));
  initial forever #25 clk = ~clk;
  // Model: any wake or mode reloads the timer
  always @(posedge clk)
    left <= (rst | wk | ms0 | ms1) ? T + 1 : (left > 0 ? left - 1 : 0);
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string s, input logic v, input logic x);
    comparisons++;
    if (v !== x) begin
      errors++;
      $display("ERROR %s exp %b got %b", s, x, v);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Power-on, timeout, wake, active, faults, sleep request
  initial begin
    void'($urandom(19));
    cyc(10);
    rst = 1'b0;
    cyc(5);
    chk("inh", regulator_inhibit_out, left > 0);
    cyc(T + 10);
    chk("inh", regulator_inhibit_out, left > 0);
    chk("slp", slp, 1'b1);
    wk = 1'b1;
    cyc(8 + $urandom % 4);
    wk = 1'b0;
    chk("irq", oen, 1'b0);
    chk("rxo", rxo, 1'b0);
    cyc(T - 15);
    chk("inh", regulator_inhibit_out, left > 0);
    cyc(25);
    chk("inh", regulator_inhibit_out, left > 0);
    host.set(1'b1, 2'($urandom % 3 + 1));
    txd = 1'b0;
    cyc(2 * T);
    chk("slp", slp, 1'b0);
    chk("inh", regulator_inhibit_out, left > 0);
    chk("rxd", oen, 1'b0);
    lg = 1'b1;
    cyc(8);
    chk("load", lden, 1'b0);
    chk("drv", drv, 1'b1);
    uv = 1'b1;
    cyc(8);
    chk("drv", drv, 1'b0);
    chk("rxd", oen, 1'b1);
    {lg, uv, txd} = 3'h1;
    host.set(1'b1, 2'h0);
    cyc(T - 10);
    chk("inh", regulator_inhibit_out, left > 0);
    cyc(20);
    chk("inh", regulator_inhibit_out, left > 0);
    finish_test();
  end
endmodule
